// ===== include/wdog_pkg.sv
// constants for the windowed watchdog: register map, field layout, reset values
// assumes a plain register port with 32-bit data and byte addresses
package wdog_pkg;

    localparam int          ADDR_W            = 4;
    localparam int          DATA_W            = 32;
    localparam int          CNT_W             = 12;

    // register offsets (byte addresses)
    localparam logic [3:0]  OFS_RESTART       = 4'h0;
    localparam logic [3:0]  OFS_CONFIG        = 4'h4;
    localparam logic [3:0]  OFS_FLAGS         = 4'h8;
    localparam logic [3:0]  OFS_IRQ_STATUS    = 4'hC;

    // restart_command fields
    localparam int          KEY_LSB           = 24;
    localparam logic [7:0]  RESTART_KEY       = 8'hA5;
    localparam int          RESTART_BIT       = 0;

    // watchdog_configuration fields
    localparam int          RELOAD_LSB        = 0;
    localparam int          FIEN_BIT          = 12;
    localparam int          RSTEN_BIT         = 13;
    localparam int          PROC_BIT          = 14;
    localparam int          DIS_BIT           = 15;
    localparam int          DELTA_LSB         = 16;
    localparam int          DBGHLT_BIT        = 28;
    localparam int          IDLEHLT_BIT       = 29;
    localparam logic [31:0] CONFIG_RESET      = 32'h3FFF_2FFF;
    localparam logic [31:0] CONFIG_MASK       = 32'h3FFF_FFFF;

    // fault_flags fields
    localparam int          UNF_BIT           = 0;
    localparam int          ERR_BIT           = 1;

    // slow clock prescale
    localparam int          PRESCALE          = 128;
    localparam logic [6:0]  PRESCALE_LAST     = 7'h7F;

endpackage

// ===== hdl/tick_divider.sv
// divider producing one-cycle tick per PRESCALE enabled slow-clock pulses
// assumes slow_en is a one-cycle enable in the clk domain
`timescale 1ns/1ps

module tick_divider
    import wdog_pkg::*;
#(
    parameter int DIV = PRESCALE
)
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic restart,
    input  wire logic slow_en,
    input  wire logic run,
    output logic      tick
);

    logic [$clog2(DIV)-1:0] count;

    always_ff @(posedge clk)
    begin
        if (!rst_b || restart)
            count <= '0;
        else if (slow_en && run)
            count <= (count == DIV[$clog2(DIV)-1:0] - 1'b1) ? '0 : count + 1'b1;
    end

    assign tick = slow_en && run && (count == DIV[$clog2(DIV)-1:0] - 1'b1);

endmodule

// ===== hdl/windowed_watchdog_timer.sv
// windowed watchdog: 12-bit down counter, keyed restart, write-once configuration
// assumes slow_en is a one-cycle pulse at the slow clock rate, synchronous to clk
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps

// Operation
// [RULE1] control write acts only when bits 31..24 equal 0xA5
// [RULE2] keyed write with bit 0 set restarts; zero there does nothing
// [RULE3] reload value field is what the counter loads
// [RULE4] interrupt enable gates underflow and error onto the interrupt
// [RULE5] reset enable gates faults onto the reset request
// [RULE6] scope bit: zero all resets, one processor reset only
// [RULE7] restart with counter at or below delta reloads counter
// [RULE8] restart with counter above delta is a window error
// [RULE9] debug halt stops counter during processor debug state
// [RULE10] idle halt stops counter during system idle
// [RULE11] disable bit stops the watchdog; only the counter stops, a restart above delta still raises a window error
// [RULE12] underflow flag set since last status read
// [RULE13] error flag set since last status read
// [RULE14] counter decrements every 128 slow clock ticks
// [RULE15] configuration writable once after processor reset
// [RULE16] status read or reset clears flags, interrupt and fault output
// [RULE17] valid restart or configuration write reloads counter and divider
// [RULE18] fault output holds until status read or reset
module windowed_watchdog_timer
    import wdog_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              slow_en,
    input  wire logic              debug_state,
    input  wire logic              idle_mode,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    output logic                   irq,
    output logic                   fault,
    output logic                   fault_all_reset,
    output logic                   fault_proc_reset
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    logic [31:0]      config_reg;
    logic             config_locked;
    logic [CNT_W-1:0] count;
    logic             flag_unf;
    logic             flag_err;
    logic             fault_q;
    logic             fault_scope_proc;
    logic [1:0]       irq_status;
    logic [1:0]       irq_enable;

    logic             restart_wr;
    logic             config_wr;
    logic             keyed_restart;
    logic             window_ok;
    logic             reload;
    logic             run;
    logic             tick;
    logic             underflow;
    logic             window_err;
    logic             flags_rd;
    logic [CNT_W-1:0] reload_value;
    logic [CNT_W-1:0] delta;

    assign reload_value  = config_reg[RELOAD_LSB +: CNT_W]; // RULE3
    assign delta         = config_reg[DELTA_LSB +: CNT_W];
    assign restart_wr    = wr && (addr == OFS_RESTART);
    assign config_wr     = wr && (addr == OFS_CONFIG) && !config_locked; // RULE15
    assign keyed_restart = restart_wr && (wdata[KEY_LSB +: 8] == RESTART_KEY) // RULE1
                           && wdata[RESTART_BIT]; // RULE2
    assign window_ok     = (count <= delta); // RULE7
    // error is raised even when the timer is disabled
    assign window_err    = keyed_restart && !window_ok; // RULE8
    assign reload        = (keyed_restart && window_ok) || config_wr; // RULE17
    assign flags_rd      = rd && (addr == OFS_FLAGS);

    assign run = !config_reg[DIS_BIT] // RULE11
                 && !(config_reg[DBGHLT_BIT] && debug_state) // RULE9
                 && !(config_reg[IDLEHLT_BIT] && idle_mode); // RULE10

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler and counter

    tick_divider #(
        .DIV     (PRESCALE)
    ) u_div (
        .clk     (clk),
        .rst_b   (rst_b),
        .restart (reload), // RULE17
        .slow_en (slow_en),
        .run     (run),
        .tick    (tick) // RULE14
    );

    // underflow when a tick finds the counter already at zero
    assign underflow = tick && (count == '0);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            count <= CONFIG_RESET[RELOAD_LSB +: CNT_W];
        else if (config_wr)
            count <= wdata[RELOAD_LSB +: CNT_W]; // RULE17
        else if (reload)
            count <= reload_value; // RULE7
        else if (tick)
            count <= count - 1'b1; // RULE14
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration, write once

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            config_reg    <= CONFIG_RESET;
            config_locked <= 1'b0;
        end
        else if (config_wr)
        begin
            config_reg    <= wdata & CONFIG_MASK;
            config_locked <= 1'b1; // RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault flags: set wins over the read clear

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            flag_unf <= 1'b0;
            flag_err <= 1'b0;
        end
        else
        begin
            flag_unf <= underflow || (flag_unf && !flags_rd); // RULE12 RULE16
            flag_err <= window_err || (flag_err && !flags_rd); // RULE13 RULE16
        end
    end

    // reset request held until flags read
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fault_q          <= 1'b0;
            fault_scope_proc <= 1'b0;
        end
        else if ((underflow || window_err) && config_reg[RSTEN_BIT]) // RULE5
        begin
            fault_q          <= 1'b1; // RULE18
            fault_scope_proc <= config_reg[PROC_BIT]; // RULE6
        end
        else if (flags_rd)
            fault_q          <= 1'b0; // RULE16
    end

    assign fault            = fault_q;
    assign fault_all_reset  = fault_q && !fault_scope_proc; // RULE6
    assign fault_proc_reset = fault_q && fault_scope_proc;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt: sticky status, write-one clear, enable

    logic irq_clr_wr;

    // enable shares the fault interrupt enable bit so software sees one switch
    assign irq_clr_wr = wr && (addr == OFS_IRQ_STATUS);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq_status <= 2'h0;
        else
        begin
            irq_status[UNF_BIT] <= underflow
                || (irq_status[UNF_BIT] && !flags_rd && !(irq_clr_wr && wdata[UNF_BIT]));
            irq_status[ERR_BIT] <= window_err
                || (irq_status[ERR_BIT] && !flags_rd && !(irq_clr_wr && wdata[ERR_BIT]));
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq_enable <= 2'h0;
        else
            irq_enable <= {2{config_reg[FIEN_BIT]}}; // RULE4
    end

    // level output, gated by enable
    assign irq = |(irq_status & irq_enable & {2{config_reg[FIEN_BIT]}}); // RULE4

    ////////////////////////////////////////////////////////////////////////////////
    // read port, data in the cycle after the strobe

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                OFS_CONFIG:     rdata <= config_reg;
                OFS_FLAGS:      rdata <= {30'h0, flag_err, flag_unf};
                OFS_IRQ_STATUS: rdata <= {30'h0, irq_status};
                default:        rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end

endmodule

// ===== bench/wdog_asserts.sv
// checker for the watchdog register port and fault outputs
// assumes it is bound to windowed_watchdog_timer, one clock
`timescale 1ns/1ps
module wdog_asserts
    import wdog_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              slow_en,
    input wire logic              debug_state,
    input wire logic              idle_mode,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              irq,
    input wire logic              fault,
    input wire logic              fault_all_reset,
    input wire logic              fault_proc_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // no tick on a quiet slow_en cycle, so no underflow can race the clear
    sequence flag_read;
        rd && addr == OFS_FLAGS && !slow_en;
    endsequence
    ////////////////////////////////////////////////////////////////
    reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !fault && !irq && rdata == '0)
        else $error("outputs not quiet after reset");
    flags_clear_a: assert property (flag_read |=> !fault && !irq)
        else $error("flag read left fault or irq");
    fault_hold_a: assert property (fault && !(rd && addr == OFS_FLAGS) |=> fault)
        else $error("fault dropped without flag read");
    scope_one_a: assert property ((fault_all_reset ^ fault_proc_reset) == fault)
        else $error("reset scope outputs inconsistent");
    scope_hold_a: assert property (fault && $past(fault) |-> $stable(fault_proc_reset))
        else $error("reset scope changed during fault");
    flags_upper_a: assert property (rd && addr == OFS_FLAGS |=> rdata[31:2] == '0)
        else $error("flag read has stray bits");
    config_mask_a: assert property (rd && addr == OFS_CONFIG |=> (rdata & ~CONFIG_MASK) == '0)
        else $error("config read has stray bits");
    bad_key_a: assert property (wr && addr == OFS_RESTART && wdata[31:24] != RESTART_KEY && !slow_en && !fault
        |=> !fault)
        else $error("unkeyed restart write acted");
endmodule
////////////////////////////////////////////////////////////////
bind windowed_watchdog_timer wdog_asserts u_wdog_asserts (.clk(clk), .rst_b(rst_b), .slow_en(slow_en),
    .debug_state(debug_state), .idle_mode(idle_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .fault(fault), .fault_all_reset(fault_all_reset), .fault_proc_reset(fault_proc_reset));

// ===== bench/fault_sink.sv
// reset controller stand-in: tallies each watchdog reset request
// assumes level requests in the clk domain, cleared by rst_b
`timescale 1ns/1ps
module fault_sink
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic fault_all_reset,
    input  wire logic fault_proc_reset,
    output int        n_all,
    output int        n_proc
);
    logic prev_all;
    logic prev_proc;
    // counts rising requests only: a held level is one reset
    always_ff @(posedge clk)
    begin
        prev_all  <= rst_b & fault_all_reset;
        prev_proc <= rst_b & fault_proc_reset;
        n_all     <= !rst_b ? 0 : n_all + int'(fault_all_reset && !prev_all);
        n_proc    <= !rst_b ? 0 : n_proc + int'(fault_proc_reset && !prev_proc);
    end
endmodule

// ===== bench/windowed_watchdog_timer_test.sv
// self-checking bench for the windowed watchdog
// assumes wdog_pkg, the design, its checker and fault_sink are compiled
`timescale 1ns/1ps
module windowed_watchdog_timer_test
    import wdog_pkg::*;
;
    logic              clk = 1'b0, rst_b = 1'b0, slow_en = 1'b0, debug_state = 1'b0, idle_mode = 1'b0;
    logic              wr = 1'b0, rd = 1'b0, irq, fault, fault_all_reset, fault_proc_reset;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, got;
    int                n_mismatch = 0, cmp_count = 0, n_all, n_proc, k;
    always #2 clk = ~clk;
    windowed_watchdog_timer u_windowed_watchdog_timer (.clk(clk), .rst_b(rst_b), .slow_en(slow_en),
        .debug_state(debug_state), .idle_mode(idle_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .fault(fault), .fault_all_reset(fault_all_reset), .fault_proc_reset(fault_proc_reset));
    fault_sink u_fault_sink (.clk(clk), .rst_b(rst_b), .fault_all_reset(fault_all_reset),
        .fault_proc_reset(fault_proc_reset), .n_all(n_all), .n_proc(n_proc));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rst();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    // trailing idle edge keeps a following strobe from a same-step reassign
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 got = rdata;
        chk(got, e);
        @(posedge clk);
    endtask
    // stops early once fault shows; k ends at n+1 if it never does
    task automatic pulses(input int n);
        for (k = 1; k <= n; k++)
        begin
            slow_en <= 1'b1; @(posedge clk); slow_en <= 1'b0; @(posedge clk); #1;
            if (fault === 1'b1) break;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rst();
        rd_chk(OFS_CONFIG, CONFIG_RESET);
        rd_chk(OFS_FLAGS, 32'h0000_0000);
        wr_reg(OFS_CONFIG, 32'h3FFF_A000);
        wr_reg(OFS_CONFIG, 32'h0000_2000);
        rd_chk(OFS_CONFIG, 32'h3FFF_A000);
        pulses(300); chk(fault, 1'b0);
    endtask
    task automatic t_window();
        rst(); wr_reg(OFS_CONFIG, 32'h0008_6010);
        wr_reg(OFS_RESTART, 32'h5A00_0001); chk(fault, 1'b0);
        wr_reg(OFS_RESTART, 32'hA500_0000); chk(fault, 1'b0);
        wr_reg(OFS_RESTART, 32'hA500_0001); chk(fault_proc_reset, 1'b1);
        chk(fault_all_reset, 1'b0); chk(irq, 1'b0);
        rd_chk(OFS_FLAGS, 32'h0000_0002); rd_chk(OFS_FLAGS, 32'h0000_0000);
        // tally moves on the edge after fault rises, so it is read once that edge has passed
        chk(n_proc, 1);
        pulses(1030); wr_reg(OFS_RESTART, 32'hA500_0001); chk(fault, 1'b0);
        pulses(1000); wr_reg(OFS_RESTART, 32'hA500_0001); chk(fault, 1'b1);
    endtask
    task automatic t_underflow();
        rst(); wr_reg(OFS_CONFIG, 32'h0FFF_3002);
        pulses(383); chk(fault, 1'b0);
        pulses(4); chk(fault_all_reset, 1'b1); chk(irq, 1'b1); chk(n_all, 1);
        rd_chk(OFS_FLAGS, 32'h0000_0001); chk(fault, 1'b0); chk(irq, 1'b0);
        rd_chk(OFS_FLAGS, 32'h0000_0000);
    endtask
    task automatic t_halt();
        rst(); wr_reg(OFS_CONFIG, 32'h3FFF_2000);
        debug_state <= 1'b1; pulses(300); chk(fault, 1'b0);
        debug_state <= 1'b0; idle_mode <= 1'b1; pulses(300); chk(fault, 1'b0);
        idle_mode <= 1'b0; pulses(130); chk(fault, 1'b1);
    endtask
    task automatic t_no_reset();
        rst(); wr_reg(OFS_CONFIG, 32'h0FFF_1000);
        pulses(130); chk(fault, 1'b0); chk(irq, 1'b1);
        wr_reg(OFS_IRQ_STATUS, 32'h0000_0001); chk(irq, 1'b0);
        rd_chk(OFS_FLAGS, 32'h0000_0001);
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        t_regs(); t_window(); t_underflow(); t_halt(); t_no_reset();
        give_verdict();
    end
    // whole run needs about 30 us
    initial
    begin
        #100us;
        n_mismatch++;
        give_verdict();
    end
endmodule
